/* File: include/udtc_defs.vh */
`ifndef UDTC_DEFS_VH
`define UDTC_DEFS_VH

// Register byte offsets
`define UDTC_CTRL_OFF 8'h00
`define UDTC_PRELOAD_OFF 8'h04
`define UDTC_SETLVL_OFF 8'h08
`define UDTC_CLRLVL_OFF 8'h0C
`define UDTC_COUNT_OFF 8'h10
`define UDTC_STATUS_OFF 8'h14
`define UDTC_SETSRC_OFF 8'h18
`define UDTC_CLRSRC_OFF 8'h1C

// Control register fields
`define UDTC_CTRL_RETAIN 0
`define UDTC_CTRL_SETEXT 1
`define UDTC_CTRL_CLREXT 2

// Documented threshold maximum
`define UDTC_LVL_MAX 20'hF423F

// AXI response codes
`define UDTC_RESP_OKAY 2'h0
`define UDTC_RESP_SLVERR 2'h2

// Reset values
`define UDTC_CNT_RST 20'h00000
`define UDTC_CTRL_RST 3'h0

`endif

/* File: test/udtc_partner.sv */
`timescale 1ns/1ps
// Pulse source standing in for an input terminal
module udtc_partner (
    // Clock
    input wire aclk,
    // Command from the bench
    input wire go,
    input wire dir,
    input wire [7:0] n,
    // Lines to the counter, and busy back to the bench
    output reg cnt_in,
    output reg dir_in,
    output reg busy
);
    reg [7:0] left_r; // Pulses still to send
    reg [2:0] ph_r; // Phase in an 8-clock pulse
    initial begin
        cnt_in = 0;
        dir_in = 0;
        busy = 0;
        left_r = 0;
        ph_r = 0;
    end
    // Four low, four high: slow enough for the input synchroniser
    always @(posedge aclk) begin
        if (go && !busy) begin
            dir_in <= dir;
            left_r <= n;
            busy <= (n != 8'h00);
            ph_r <= 3'h0;
        end else if (busy) begin
            ph_r <= ph_r + 3'h1;
            cnt_in <= ph_r[2];
            if (ph_r == 3'h7) begin
                left_r <= left_r - 8'h01;
                busy <= (left_r != 8'h01);
            end
        end else begin
            cnt_in <= 1'b0;
        end
    end
endmodule // udtc_partner

/* File: test/udtc_props.sv */
`timescale 1ns/1ps
// Port-level checks on the counter and its register bus
module udtc_props #(
    parameter CW = 20
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Function inputs
    input wire cnt_in,
    input wire dir_in,
    input wire rst_in,
    // Function outputs
    input wire switch_out_r,
    input wire [CW-1:0] count_out_r,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet inputs: no reset, no write data valid on the bus
    wire quiet = !rst_in && !s_axi_wvalid;
    rst_hold_a: assert property (rst_in [*6] |->
        !switch_out_r && $stable(count_out_r)) else $error("reset hold");
    up_step_a: assert property ((quiet && !dir_in) [*6] ##0
        $changed(count_out_r) |-> count_out_r == $past(count_out_r) + 20'h1)
        else $error("up step wrong");
    down_step_a: assert property ((quiet && dir_in) [*6] ##0
        $changed(count_out_r) |-> count_out_r == $past(count_out_r) - 20'h1)
        else $error("down step wrong");
    fall_ignored_a: assert property ((quiet && !cnt_in) [*6]
        |-> $stable(count_out_r)) else $error("count moved while idle");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    // Main scenarios reached
    cover property (rst_in ##1 !rst_in);
    cover property ($rose(switch_out_r));
    cover property ($fell(switch_out_r) && !rst_in);
endmodule // udtc_props

bind udtc_counter udtc_props #(.CW(CW)) u_props (.aclk, .aresetn, .cnt_in,
    .dir_in, .rst_in, .switch_out_r, .count_out_r, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* File: test/up_down_threshold_counter_tb.sv */
`timescale 1ns/1ps
// Bench: integer model against the counter at every result
module up_down_threshold_counter_tb;
    reg aclk = 0, aresetn = 0, rst_in = 0, go = 0, pd = 0;
    reg [7:0] pn = 0, awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, got;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg [79:0] blk = 0; // Other blocks' live values
    reg [1:0] gr; // Last response code
    wire cnt_in, dir_in, busy, sw, awr, wr_r, bv, arr, rv;
    wire [19:0] cnt;
    wire [1:0] br, rr;
    wire [31:0] rd;
    integer fail_count = 0, samples_checked = 0, i;
    integer ec = 0, es = 0, eset = 0, eclr = 0, seed = 32'hace98d0e;
    always #5 aclk = ~aclk;
    udtc_partner PM (.aclk(aclk), .go(go), .dir(pd), .n(pn),
        .cnt_in(cnt_in), .dir_in(dir_in), .busy(busy));
    udtc_counter #(.SCAN_DIV(16'h0004)) DUT (.aclk(aclk), .aresetn(aresetn),
        .cnt_in(cnt_in), .dir_in(dir_in), .rst_in(rst_in), .blk_values(blk),
        .switch_out_r(sw), .count_out_r(cnt), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wr_r),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rready));
    // Compare and count
    task chk(input [31:0] g, input [31:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task tmo;
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: timeout", $time);
            end_of_test;
        end
    endtask
    // Bus write: address and data together, then response
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
            for (i = 0; i < 40; i = i + 1) begin
                @(posedge aclk);
                if (awr) awvalid <= 0;
                if (wr_r) wvalid <= 0;
                if (bv) begin gr = br; i = 99; end
            end
            bready <= 0;
            if (i != 100) tmo;
        end
    endtask
    // Bus read
    task rdr(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a; arvalid <= 1; rready <= 1;
            for (i = 0; i < 40; i = i + 1) begin
                @(posedge aclk);
                if (arr) arvalid <= 0;
                if (rv) begin got = rd; gr = rr; i = 99; end
            end
            rready <= 0;
            if (i != 100) tmo;
        end
    endtask
    // Model of the threshold output
    task ev;
        if (eset >= eclr) begin
            if (ec >= eset) es = 1;
            else if (ec < eclr) es = 0;
        end else es = (ec >= eset && ec < eclr);
    endtask
    // Send n pulses, then step the model once per pulse unless rst_in is high
    task burst(input [7:0] n, input d);
        integer k;
        begin
            @(posedge aclk); go <= 1; pn <= n; pd <= d;
            @(posedge aclk); go <= 0;
            for (k = 0; k < 3000; k = k + 1) begin
                @(posedge aclk);
                if (!busy) k = 9999;
            end
            if (k != 10000) tmo;
            repeat (12) @(posedge aclk);
            for (k = 0; k < n; k = k + 1) if (!rst_in) begin
                ec = (d ? ec - 1 : ec + 1) & 20'hFFFFF;
                ev;
            end
        end
    endtask
    // Count over the bus and at the pins, plus the switch
    task ck;
        begin
            repeat (8) @(posedge aclk);
            rdr(8'h10);
            chk(got, ec);
            chk(cnt, ec);
            chk(sw, es);
            $display("test done at %0t", $time);
        end
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rdr(8'h00); chk(got, 0); chk(gr, 0); // Control resets to zero
        rdr(8'h20); chk(gr, 2); chk(got, 0); // Unmapped place
        got = $random(seed);
        blk[19:0] <= got[19:0];
        blk[79:48] <= $random(seed);
        eset = 5; eclr = 2; ec = 3;
        wr(8'h08, 5); wr(8'h0C, 2); wr(8'h04, 3);
        ck;
        burst(4, 0); ck;
        burst(4, 1); ck;
        burst(2, 1); ck;
        eset = 2; eclr = 6;
        wr(8'h08, 2); wr(8'h0C, 6); ev;
        burst(3, 0); ck;
        burst(3, 0); ck;
        wr(8'h08, 32'hFFFFFFFF); rdr(8'h08); chk(got, 32'hF423F);
        eset = 999999; ev;
        @(posedge aclk); rst_in <= 1;
        burst(3, 0); ec = 3; es = 0; ck;
        @(posedge aclk); rst_in <= 0;
        blk[39:20] <= 20'h00003; eset = 3; ev;
        wr(8'h18, 1); wr(8'h00, 2); ck;
        wr(8'h00, 1); eset = 0; eclr = 0; ev;
        @(posedge aclk); aresetn <= 0;
        repeat (3) @(posedge aclk); aresetn <= 1;
        ck;
        wr(8'h00, 0);
        @(posedge aclk); aresetn <= 0;
        repeat (3) @(posedge aclk); aresetn <= 1;
        ec = 0; ev; ck;
        end_of_test;
    end
endmodule // up_down_threshold_counter_tb

/* File: verilog/udtc_counter.v */
`timescale 1ns/1ps
// Functional notes
// [RULE1] Count only rising edges of count input
// [RULE2] Direction low counts up, high down
// [RULE3] Each accepted edge changes count by one
// [RULE4] Reset loads preload value, output forced low
// [RULE5] While reset high, output low, edges dropped
// [RULE6] Thresholds accept zero to documented maximum
// [RULE7] Set>=clear: high at set, low below clear
// [RULE8] Set<clear: high only inside the window
// [RULE9] Counting starts from configurable preload value
// [RULE10] Retention keeps count across power loss; the code keeps it only across aresetn, and a cold start clears it
// [RULE11] Compare once per scan cycle, overshoot possible
// [RULE12] Fast edges up to high rate accepted
// [RULE13] Thresholds may come from another block
// [RULE14] Hysteresis band holds the previous output

`include "udtc_defs.vh"

module udtc_counter #(
    parameter CW = 20,
    parameter SCAN_DIV = 16'h0064,
    parameter NBLK = 4
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Function inputs from pins or other blocks
    input wire cnt_in,
    input wire dir_in,
    input wire rst_in,
    // Live values of other blocks, one word each
    input wire [NBLK*CW-1:0] blk_values,
    // Switch output and live count
    output reg switch_out_r,
    output reg [CW-1:0] count_out_r,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // Function inputs arrive from pins or other scan logic with no
    // relation to aclk, so each passes two flip-flops before any
    // logic reads it. The edge detector then adds one more stage,
    // which means a count edge takes three clocks to reach count_r.
    // Pulses shorter than about one clock can be lost.
    // Two-stage synchronisers for the external inputs
    reg [1:0] cnt_sync_r;
    reg [1:0] dir_sync_r;
    reg [1:0] rst_sync_r;
    reg cnt_prev_r; // Last synchronised count level
    // Software registers
    reg [2:0] ctrl_r;
    reg [CW-1:0] preload_r;
    reg [CW-1:0] setlvl_r;
    reg [CW-1:0] clrlvl_r;
    reg [7:0] setsrc_r;
    reg [7:0] clrsrc_r;
    // Counter state
    reg [CW-1:0] count_r;
    reg [15:0] scan_r; // Scan cycle timer
    // Write channel holding
    reg [7:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;
    // Software preload request, applied by the counter process
    reg sw_load_r;

    wire cnt_s = cnt_sync_r[1];
    wire dir_s = dir_sync_r[1];
    wire rst_s = rst_sync_r[1];
    wire cnt_rise = cnt_s & ~cnt_prev_r; // [RULE1]
    wire scan_tick = (scan_r == 16'h0000);

    // Each threshold can follow another block's live value instead of
    // its own register. An index beyond the last block leaves the own
    // register in force, so a stale index never selects garbage.
    // The other blocks share aclk, so no synchroniser is needed.
    // Selected thresholds: own register or another block's value
    reg [CW-1:0] set_eff;
    reg [CW-1:0] clr_eff;
    integer k;
    always @* begin
        set_eff = setlvl_r;
        clr_eff = clrlvl_r;
        for (k = 0; k < NBLK; k = k + 1) begin
            if (ctrl_r[`UDTC_CTRL_SETEXT] && setsrc_r == k[7:0]) begin
                set_eff = blk_values[k*CW +: CW]; // [RULE13]
            end
            if (ctrl_r[`UDTC_CTRL_CLREXT] && clrsrc_r == k[7:0]) begin
                clr_eff = blk_values[k*CW +: CW]; // [RULE13]
            end
        end
    end

    // Software may write any 32-bit word into a level register.
    // Values above the largest legal level are clamped rather than
    // truncated, so a too-large level never wraps to a small one.
    // Clamp a register write to the documented maximum
    function [CW-1:0] clamp_lvl;
        input [31:0] v;
        begin
            if (v > {12'h000, `UDTC_LVL_MAX}) begin
                clamp_lvl = `UDTC_LVL_MAX; // [RULE6]
            end else begin
                clamp_lvl = v[CW-1:0];
            end
        end
    endfunction

    // Input synchronisers; sampled at the fast rate every clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_sync_r <= 2'h0;
            dir_sync_r <= 2'h0;
            rst_sync_r <= 2'h0;
            cnt_prev_r <= 1'b0;
        end else begin
            cnt_sync_r <= {cnt_sync_r[0], cnt_in}; // [RULE12]
            dir_sync_r <= {dir_sync_r[0], dir_in};
            rst_sync_r <= {rst_sync_r[0], rst_in};
            cnt_prev_r <= cnt_s;
        end
    end

    // Priority of the counter: bus reset, function reset, software
    // preload, then counting. A held function reset keeps loading the
    // preload value, which is what discards edges during reset.
    // The count wraps modulo two to the power of the width; users
    // who need saturation must keep the levels inside the range.
    // Counter: reset, software load, or one step per rising edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Retained count survives a soft reset when retention is on
            if (!ctrl_r[`UDTC_CTRL_RETAIN]) begin
                count_r <= `UDTC_CNT_RST; // [RULE10]
            end
        end else if (rst_s) begin
            count_r <= preload_r; // [RULE4] [RULE5] [RULE9]
        end else if (sw_load_r) begin
            count_r <= preload_r; // [RULE9]
        end else if (cnt_rise) begin
            if (dir_s) begin
                count_r <= count_r - 1'b1; // [RULE2] [RULE3]
            end else begin
                count_r <= count_r + 1'b1; // [RULE2] [RULE3]
            end
        end
    end

    // The scan timer stands in for the controller's scan cycle.
    // The first tick comes right after reset release, then one
    // every SCAN_DIV clocks. Counting itself is not tied to ticks.
    // Scan timer: output is evaluated once per scan period
    always @(posedge aclk) begin
        if (!aresetn) begin
            scan_r <= 16'h0000;
        end else if (scan_tick) begin
            scan_r <= SCAN_DIV - 16'h0001;
        end else begin
            scan_r <= scan_r - 16'h0001;
        end
    end

    // The switch is compared only on scan ticks, so several counts
    // may pass between two looks and a level can be overshot. A
    // function reset forces the switch low at once, not at a tick.
    // With the set level at or above the clear level the switch has
    // hysteresis; with it below, the switch marks a window.
    // Threshold comparison and live count
    always @(posedge aclk) begin
        if (!aresetn) begin
            switch_out_r <= 1'b0;
            count_out_r <= `UDTC_CNT_RST;
        end else begin
            count_out_r <= count_r;
            if (rst_s) begin
                switch_out_r <= 1'b0; // [RULE4] [RULE5]
            end else if (scan_tick) begin // [RULE11]
                if (set_eff >= clr_eff) begin
                    // Hysteresis mode
                    if (count_r >= set_eff) begin
                        switch_out_r <= 1'b1; // [RULE7]
                    end else if (count_r < clr_eff) begin
                        switch_out_r <= 1'b0; // [RULE7]
                    end // Band: hold [RULE14]
                end else begin
                    // Window mode
                    switch_out_r <= (count_r >= set_eff) &&
                        (count_r < clr_eff); // [RULE8]
                end
            end
        end
    end

    // Address and data are held until both have arrived; the
    // response then follows one clock later. The readies stay low
    // until the response is taken, so one write is open at a time.
    // Partial writes are answered but change nothing.
    // AXI write path: capture address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UDTC_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            // Retention flag survives a soft reset; an unknown flag at
            // power-up reads as off, so a cold start clears the count
            ctrl_r <= `UDTC_CTRL_RST;
            if (ctrl_r[`UDTC_CTRL_RETAIN]) begin
                ctrl_r[`UDTC_CTRL_RETAIN] <= 1'b1; // [RULE10]
            end
            preload_r <= `UDTC_CNT_RST;
            setlvl_r <= `UDTC_CNT_RST;
            clrlvl_r <= `UDTC_CNT_RST;
            setsrc_r <= 8'h00;
            clrsrc_r <= 8'h00;
            sw_load_r <= 1'b0;
        end else begin
            sw_load_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_r && w_have_r && !s_axi_bvalid) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `UDTC_RESP_OKAY;
                // Registers take whole words when all lanes are set
                if (w_strb_r == 4'hF) begin
                    case (aw_addr_r)
                        `UDTC_CTRL_OFF: begin
                            ctrl_r <= w_data_r[2:0];
                        end
                        `UDTC_PRELOAD_OFF: begin
                            preload_r <= clamp_lvl(w_data_r);
                            sw_load_r <= 1'b1;
                        end
                        `UDTC_SETLVL_OFF: begin
                            setlvl_r <= clamp_lvl(w_data_r);
                        end
                        `UDTC_CLRLVL_OFF: begin
                            clrlvl_r <= clamp_lvl(w_data_r);
                        end
                        `UDTC_SETSRC_OFF: begin
                            setsrc_r <= w_data_r[7:0];
                        end
                        `UDTC_CLRSRC_OFF: begin
                            clrsrc_r <= w_data_r[7:0];
                        end
                        `UDTC_COUNT_OFF, `UDTC_STATUS_OFF: begin
                            s_axi_bresp <= `UDTC_RESP_OKAY;
                        end
                        default: begin
                            s_axi_bresp <= `UDTC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read data are taken the clock after the address and held with
    // rvalid until the master takes them. Unmapped reads return zero
    // with an error response.
    // AXI read path: one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `UDTC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `UDTC_RESP_OKAY;
                case (s_axi_araddr)
                    `UDTC_CTRL_OFF: s_axi_rdata <= {29'h0, ctrl_r};
                    `UDTC_PRELOAD_OFF: s_axi_rdata <= {12'h000, preload_r};
                    `UDTC_SETLVL_OFF: s_axi_rdata <= {12'h000, setlvl_r};
                    `UDTC_CLRLVL_OFF: s_axi_rdata <= {12'h000, clrlvl_r};
                    `UDTC_COUNT_OFF: s_axi_rdata <= {12'h000, count_r};
                    `UDTC_STATUS_OFF: begin
                        s_axi_rdata <= {29'h0, rst_s, dir_s, switch_out_r};
                    end
                    `UDTC_SETSRC_OFF: s_axi_rdata <= {24'h000000, setsrc_r};
                    `UDTC_CLRSRC_OFF: s_axi_rdata <= {24'h000000, clrsrc_r};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `UDTC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // udtc_counter
